// >>> core/tcpf_framer.sv
// Tilt angle to 5-byte CAN data field framer
`include "tcpf_defines.svh"

module tcpf_framer #(
    parameter int CNT_W      = 25,
    parameter int WARM_FAST  = `TCPF_WARM_FAST_MS * `TCPF_CLK_KHZ,
    parameter int WARM_SLOW  = `TCPF_WARM_SLOW_MS * `TCPF_CLK_KHZ,
    parameter int SETL_FAST  = `TCPF_SETTLE_FAST_MS * `TCPF_CLK_KHZ,
    parameter int SETL_SLOW  = `TCPF_SETTLE_SLOW_MS * `TCPF_CLK_KHZ,
    parameter int FRAME_CYC  = `TCPF_CLK_HZ / `TCPF_UPDATE_HZ
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                strap_hi,
    input  wire logic                strap_lo,
    input  wire logic                factory_id_en,
    input  wire tcpf_pkg::tcpf_id_t  factory_id,
    input  wire logic                wide_range_model,
    input  wire logic                slow_damping,
    input  wire logic                fine_resolution_option,
    input  wire logic                wdog_restart,
    input  wire logic                sync_lost,
    input  wire logic                orientation_step,
    input  wire logic [15:0]         pitch_angle,
    input  wire logic [15:0]         roll_angle,
    input  wire logic [15:0]         spin_angle,
    input  wire logic [15:0]         axis_incline,
    input  wire logic                tx_ready,
    output logic                     tx_valid,
    output logic [7:0]               tx_data,
    output logic                     tx_last,
    output tcpf_pkg::tcpf_id_t       node_id,
    output logic [7:0]               node_addr,
    output logic [1:0]               node_priority,
    output tcpf_pkg::tcpf_mode_e     meas_mode,
    output logic                     warming_up,
    output logic                     settling,
    output logic                     frame_skipped
);

    localparam logic [CNT_W-1:0] WARM_F = CNT_W'(WARM_FAST - 1);
    localparam logic [CNT_W-1:0] WARM_S = CNT_W'(WARM_SLOW - 1);
    localparam logic [CNT_W-1:0] SETL_F = CNT_W'(SETL_FAST - 1);
    localparam logic [CNT_W-1:0] SETL_S = CNT_W'(SETL_SLOW - 1);
    localparam logic [CNT_W-1:0] FRM_END = CNT_W'(FRAME_CYC - 1);

    tcpf_pkg::tcpf_state_e state;
    tcpf_pkg::tcpf_id_t    strap_now;
    tcpf_pkg::tcpf_id_t    strap_boot;
    tcpf_pkg::tcpf_id_t    id_pick;
    logic                  id_done;
    logic                  slow_lat;
    logic                  wdog_lat;
    logic [CNT_W-1:0]      warm_cnt;
    logic [CNT_W-1:0]      warm_end;
    logic [CNT_W-1:0]      setl_cnt;
    logic [CNT_W-1:0]      setl_end;
    logic [CNT_W-1:0]      frm_cnt;
    logic                  frame_tick;
    logic                  id_fault;
    logic [15:0]           first_raw;
    logic [15:0]           second_raw;
    logic [15:0]           first_max;
    logic [15:0]           second_max;
    logic [15:0]           first_val;
    logic [15:0]           second_val;
    logic [7:0]            status_now;
    logic [15:0]           shd_first;
    logic [15:0]           shd_second;
    logic [7:0]            shd_status;
    logic [2:0]            byte_idx;
    logic [7:0]            push_byte;
    logic                  push_last;
    logic                  buf_in_valid;
    logic                  buf_in_ready;
    logic [8:0]            buf_out;

    // open strap reads one, grounded reads zero
    assign strap_now = {strap_hi, strap_lo};

    assign id_pick = factory_id_en ? factory_id : strap_now;

    // single capture on the first cycle after reset release
    always_ff @(posedge clk) begin
        if (rst) begin
            id_done       <= 1'b0;
            strap_boot    <= 2'h0;
            node_id       <= 2'h0;
            node_addr     <= 8'h00;
            node_priority <= 2'h0;
            meas_mode     <= tcpf_pkg::TCPF_SINGLE;
            slow_lat      <= 1'b0;
            wdog_lat      <= 1'b0;
        end else if (!id_done) begin
            id_done       <= 1'b1;
            strap_boot    <= strap_now;
            node_id       <= id_pick;
            // address and priority follow the id
            node_addr     <= `TCPF_ADDR_BASE + {6'h00, id_pick};
            node_priority <= id_pick;
            // id 3 is the two-angle mode
            if (id_pick == `TCPF_DUAL_ID) begin
                meas_mode <= wide_range_model ? tcpf_pkg::TCPF_GIMBAL
                                              : tcpf_pkg::TCPF_DUAL;
            end else begin
                meas_mode <= wide_range_model ? tcpf_pkg::TCPF_TILT
                                              : tcpf_pkg::TCPF_SINGLE;
            end
            slow_lat      <= slow_damping;
            // restart cause caught once, kept until next reset
            wdog_lat      <= wdog_restart;
        end
    end

    // live compare against the boot capture
    assign id_fault = id_done && (strap_now != strap_boot);

    // warm-up length picked by the damping option
    assign warm_end = slow_lat ? WARM_S : WARM_F;

    always_ff @(posedge clk) begin
        if (rst) begin
            warming_up <= 1'b1;
            warm_cnt   <= '0;
        end else if (id_done && warming_up) begin
            if (warm_cnt == warm_end) begin
                warming_up <= 1'b0;
            end
            warm_cnt <= warm_cnt + 1'b1;
        end
    end

    assign setl_end = slow_lat ? SETL_S : SETL_F;

    // A new step restarts the window, as the filter restarts too
    always_ff @(posedge clk) begin
        if (rst) begin
            settling <= 1'b0;
            setl_cnt <= '0;
        end else if (orientation_step) begin
            settling <= 1'b1;
            setl_cnt <= '0;
        end else if (settling) begin
            if (setl_cnt == setl_end) begin
                settling <= 1'b0;
            end
            setl_cnt <= setl_cnt + 1'b1;
        end
    end

    // update-rate divider gives a one-cycle tick
    assign frame_tick = id_done && (frm_cnt == FRM_END);

    always_ff @(posedge clk) begin
        if (rst) begin
            frm_cnt <= '0;
        end else if (id_done) begin
            frm_cnt <= frame_tick ? '0 : frm_cnt + 1'b1;
        end
    end

    // single-axis sends spin then axis incline
    // other modes send pitch then roll
    always_comb begin
        if (meas_mode == tcpf_pkg::TCPF_SINGLE) begin
            first_raw  = spin_angle;
            second_raw = axis_incline;
        end else begin
            first_raw  = pitch_angle;
            second_raw = roll_angle;
        end
    end

    assign first_max  = fine_resolution_option ? `TCPF_F_MAX1 : `TCPF_C_MAX1;
    assign second_max = fine_resolution_option ? `TCPF_F_MAX2 : `TCPF_C_MAX2;

    // Clamp so a filter glitch never leaves the documented range
    assign first_val  = (first_raw  > first_max)  ? first_max  : first_raw;
    assign second_val = (second_raw > second_max) ? second_max : second_raw;

    // status bits, zero when all is well
    always_comb begin
        status_now                 = 8'h00;
        status_now[`TCPF_ST_WARM]  = warming_up;
        status_now[`TCPF_ST_SYNC]  = sync_lost;
        status_now[`TCPF_ST_IDCHG] = id_fault;
        status_now[`TCPF_ST_WDOG]  = wdog_lat;
    end

    // frames start on each tick that finds the framer idle, no host request involved
    always_ff @(posedge clk) begin
        if (rst) begin
            state    <= tcpf_pkg::TCPF_IDLE;
            byte_idx <= 3'h0;
        end else begin
            case (state)
                tcpf_pkg::TCPF_IDLE: begin
                    if (frame_tick) begin
                        state    <= tcpf_pkg::TCPF_SEND;
                        byte_idx <= 3'h0;
                    end
                end
                tcpf_pkg::TCPF_SEND: begin
                    if (buf_in_ready) begin
                        if (byte_idx == `TCPF_LAST_BYTE) begin
                            state <= tcpf_pkg::TCPF_IDLE;
                        end
                        byte_idx <= byte_idx + 3'h1;
                    end
                end
                default: begin
                    state <= tcpf_pkg::TCPF_IDLE;
                end
            endcase
        end
    end

    // Snapshot keeps one frame coherent while bytes trickle out
    always_ff @(posedge clk) begin
        if (rst) begin
            shd_first  <= 16'h0000;
            shd_second <= 16'h0000;
            shd_status <= 8'h00;
        end else if (frame_tick && state == tcpf_pkg::TCPF_IDLE) begin
            shd_first  <= first_val;
            shd_second <= second_val;
            shd_status <= status_now;
        end
    end

    // A stalled receiver costs whole frames, never half of one
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_skipped <= 1'b0;
        end else begin
            frame_skipped <= frame_tick && (state != tcpf_pkg::TCPF_IDLE);
        end
    end

    always_comb begin
        case (byte_idx)
            3'h0:    push_byte = shd_first[7:0];
            3'h1:    push_byte = shd_first[15:8];
            3'h2:    push_byte = shd_second[7:0];
            3'h3:    push_byte = shd_second[15:8];
            default: push_byte = shd_status;
        endcase
    end

    assign push_last    = (byte_idx == `TCPF_LAST_BYTE);
    assign buf_in_valid = (state == tcpf_pkg::TCPF_SEND);

    tcpf_buf2 #(
        .WIDTH (9),
        .DEPTH (2),
        .AW    (1)
    ) u_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   ({push_last, push_byte}),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (buf_out)
    );

    assign tx_data = buf_out[7:0];
    assign tx_last = buf_out[8];

    // Checks
    logic [CNT_W-1:0] since_boot;
    logic [CNT_W-1:0] since_tick;
    logic             push;

    assign push = buf_in_valid && buf_in_ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            since_boot <= '0;
            since_tick <= '0;
        end else begin
            if (id_done && since_boot != '1) begin
                since_boot <= since_boot + 1'b1;
            end
            since_tick <= frame_tick ? '0 : since_tick + 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_warm_length: assert property (
        $fell(warming_up) |-> since_boot == warm_end + 1'b1)
        else $error("warm-up ended at the wrong cycle");

    chk_settle_len: assert property (
        settling && setl_cnt == setl_end && !orientation_step |=> !settling)
        else $error("settling window did not close on time");

    chk_tick_period: assert property (
        frame_tick && $past(id_done) && since_boot > FRM_END |-> since_tick == FRM_END)
        else $error("frame tick spacing wrong");

    chk_frame_start: assert property (
        frame_tick && state == tcpf_pkg::TCPF_IDLE |=>
            state == tcpf_pkg::TCPF_SEND && byte_idx == 3'h0)
        else $error("tick did not start a frame");

    chk_strap_open: assert property (
        !id_done && !factory_id_en |=> node_id == $past(strap_now))
        else $error("strap id not taken as read");

    chk_addr_map: assert property (
        id_done |-> node_addr == `TCPF_ADDR_BASE + {6'h00, node_id}
                    && node_priority == node_id)
        else $error("address or priority does not follow id");

    chk_mode_map: assert property (
        id_done && !wide_range_model && node_id != `TCPF_DUAL_ID |->
            meas_mode == tcpf_pkg::TCPF_SINGLE || $changed(wide_range_model))
        else $error("mode does not follow id");

    chk_five_bytes: assert property (
        push && byte_idx == 3'h0 |-> ##[1:300] push && push_last)
        else $error("frame not closed after five bytes");

    chk_byte_order: assert property (
        push && byte_idx == 3'h1 |-> push_byte == shd_first[15:8])
        else $error("high byte out of place");

    chk_single_src: assert property (
        meas_mode == tcpf_pkg::TCPF_SINGLE && spin_angle <= first_max |->
            first_val == spin_angle)
        else $error("single-axis first angle not spin");

    chk_coarse_clamp: assert property (
        !fine_resolution_option |-> first_val <= `TCPF_C_MAX1
                                    && second_val <= `TCPF_C_MAX2)
        else $error("coarse angle out of range");

    chk_fine_clamp: assert property (
        fine_resolution_option |-> first_val <= `TCPF_F_MAX1
                                   && second_val <= `TCPF_F_MAX2)
        else $error("fine angle out of range");

    chk_status_warm: assert property (
        frame_tick && state == tcpf_pkg::TCPF_IDLE |=>
            shd_status[`TCPF_ST_WARM] == $past(warming_up)
            && shd_status[`TCPF_ST_SYNC] == $past(sync_lost))
        else $error("status warm or sync bit wrong");

    chk_id_fault: assert property (
        frame_tick && state == tcpf_pkg::TCPF_IDLE && strap_now != strap_boot |=>
            shd_status[`TCPF_ST_IDCHG])
        else $error("wiring fault not flagged");

    chk_wdog_flag: assert property (
        $past(id_done) |-> $stable(wdog_lat) && status_now[`TCPF_ST_WDOG] == wdog_lat)
        else $error("watchdog flag changed after boot");

    chk_id_hold: assert property (
        $past(id_done) |-> $stable(node_id) && $stable(node_addr))
        else $error("identity changed after capture");

    cov_frame_sent: cover property (push && push_last);
    cov_warm_done:  cover property ($fell(warming_up));
    cov_skipped:    cover property (frame_skipped);
    cov_id_fault:   cover property (id_fault && frame_tick);

endmodule

// >>> core/tcpf_defines.svh
// Constants for the tilt CAN payload framer
`ifndef TCPF_DEFINES_SVH
`define TCPF_DEFINES_SVH

`define TCPF_CLK_HZ          20000000
`define TCPF_CLK_KHZ         20000
`define TCPF_WARM_FAST_MS    200
`define TCPF_WARM_SLOW_MS    1000
`define TCPF_SETTLE_FAST_MS  100
`define TCPF_SETTLE_SLOW_MS  500
`define TCPF_UPDATE_HZ       40

`define TCPF_ADDR_BASE       8'ha2
`define TCPF_LAST_BYTE       3'h4
`define TCPF_DUAL_ID         2'h3

`define TCPF_ST_WARM         0
`define TCPF_ST_SYNC         4
`define TCPF_ST_IDCHG        6
`define TCPF_ST_WDOG         7

`define TCPF_C_MAX1          16'h0e0f
`define TCPF_C_MAX2          16'h0708
`define TCPF_F_MAX1          16'h8c9f
`define TCPF_F_MAX2          16'h4650

`endif

// >>> core/tcpf_pkg.sv
// Types for the tilt CAN payload framer
package tcpf_pkg;

    typedef enum logic [1:0] {
        TCPF_IDLE = 2'h0,
        TCPF_SEND = 2'h1
    } tcpf_state_e;

    typedef enum logic [1:0] {
        TCPF_SINGLE = 2'h0,
        TCPF_DUAL   = 2'h1,
        TCPF_TILT   = 2'h2,
        TCPF_GIMBAL = 2'h3
    } tcpf_mode_e;

    typedef logic [1:0] tcpf_id_t;

endpackage

// >>> core/tcpf_buf2.sv
// Small valid/ready buffer between framer and CAN controller
module tcpf_buf2 #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2,
    parameter int AW    = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // DEPTH must be a power of two so the pointers wrap by themselves
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

// >>> testbench/tcpf_host_model.sv
// Receiving host model that collects five-byte frames from the framer
module tcpf_host_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        stall,
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_last,
    output logic             tx_ready,
    output logic [39:0]      frame,
    output int               frame_cnt,
    output int               len_err
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0] acc;
    int          idx;

    // Stall on demand so the buffer must hold words
    assign tx_ready = !stall;

    // five bytes, last flag on the fifth
    // Plain always, as the initial block also seeds these counters
    always @(posedge clk) begin
        if (rst) begin
            idx <= 0;
        end else if (tx_valid && tx_ready) begin
            if (tx_last) begin
                frame <= {tx_data, acc};
                frame_cnt <= frame_cnt + 1;
                if (idx != 4) begin
                    len_err <= len_err + 1;
                end
                idx <= 0;
            end else begin
                if (idx < 4) begin
                    acc[idx*8 +: 8] <= tx_data;
                end
                idx <= idx + 1;
            end
        end
    end

    initial begin
        frame_cnt = 0;
        len_err = 0;
        frame = '0;
        acc = '0;
    end
endmodule

// >>> testbench/tilt_can_payload_framer_test.sv
// Self-checking bench for the tilt CAN payload framer
module tilt_can_payload_framer_test;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int WF = 40;
    localparam int WS = 100;
    localparam int SF = 20;
    localparam int SS = 50;
    localparam int FC = 30;
    localparam int LIMIT = 20000;

    typedef struct {
        logic [1:0]  id;
        logic        wide;
        logic        fine;
        logic        sync;
        logic        wdog;
        logic [15:0] a1;
        logic [15:0] a2;
    } tcpf_row_s;

    logic clk = 0, rst = 1, strap_hi = 1, strap_lo = 1, factory_id_en = 0, wide = 0;
    logic slow = 0, fine = 0, wdog = 0, sync_lost = 0, step = 0, stall = 0;
    tcpf_pkg::tcpf_id_t factory_id = 2'h0;
    logic [15:0] pitch = 0, roll = 0, spin = 0, incline = 0;
    logic tx_ready, tx_valid, tx_last, warming_up, settling, frame_skipped;
    logic [7:0] tx_data, node_addr;
    logic [1:0] node_priority;
    tcpf_pkg::tcpf_id_t node_id;
    tcpf_pkg::tcpf_mode_e meas_mode;
    logic [39:0] frame;
    int frame_cnt, len_err, errors = 0, samples_checked = 0, cycles = 0, t0, n;
    logic seen;
    tcpf_row_s rows [8] = '{
        '{2'h0, 0, 0, 0, 0, 16'h0e0f, 16'h0708}, '{2'h1, 0, 0, 1, 0, 16'h0e10, 16'h0709},
        '{2'h2, 0, 1, 0, 1, 16'h8c9f, 16'h4650}, '{2'h3, 0, 1, 0, 0, 16'h8ca0, 16'h4651},
        '{2'h3, 1, 0, 1, 1, 16'h0123, 16'h0456}, '{2'h0, 1, 1, 0, 0, 16'h1234, 16'h0a0b},
        '{2'h1, 1, 0, 0, 0, 16'h0000, 16'h0000}, '{2'h2, 1, 1, 0, 0, 16'hffff, 16'hffff}};

    always #25 clk = ~clk;

    tcpf_framer #(.WARM_FAST(WF), .WARM_SLOW(WS), .SETL_FAST(SF), .SETL_SLOW(SS),
                  .FRAME_CYC(FC)) tcpf_framer_inst (
        .clk(clk), .rst(rst), .strap_hi(strap_hi), .strap_lo(strap_lo),
        .factory_id_en(factory_id_en), .factory_id(factory_id), .wide_range_model(wide),
        .slow_damping(slow), .fine_resolution_option(fine), .wdog_restart(wdog),
        .sync_lost(sync_lost), .orientation_step(step), .pitch_angle(pitch),
        .roll_angle(roll), .spin_angle(spin), .axis_incline(incline), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .node_id(node_id),
        .node_addr(node_addr), .node_priority(node_priority), .meas_mode(meas_mode),
        .warming_up(warming_up), .settling(settling), .frame_skipped(frame_skipped));

    tcpf_host_model tcpf_host_model_inst (
        .clk(clk), .rst(rst), .stall(stall), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready), .frame(frame), .frame_cnt(frame_cnt),
        .len_err(len_err));

    task automatic check(string what, logic [39:0] got, logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // open straps read as one, grounded as zero
    task automatic boot(logic [1:0] id, logic w, logic s, logic wd);
        @(negedge clk);
        {strap_hi, strap_lo} = id;
        wide = w;
        slow = s;
        wdog = wd;
        rst = 1;
        repeat (16) @(negedge clk);
        rst = 0;
        t0 = cycles;
        repeat (2) @(negedge clk);
    endtask

    task automatic next_frame();
        int c0;
        c0 = frame_cnt;
        while (frame_cnt == c0) @(negedge clk);
    endtask

    task automatic warm_end();
        while (warming_up !== 1'b0) @(negedge clk);
    endtask

    function automatic logic [15:0] clamp(logic [15:0] v, logic [15:0] mx);
        return (v > mx) ? mx : v;
    endfunction

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            summarize();
        end
    end

    initial begin
        tcpf_row_s r;
        tcpf_pkg::tcpf_mode_e m;
        logic [15:0] e1, e2;
        foreach (rows[i]) begin
            r = rows[i];
            fine = r.fine;
            sync_lost = r.sync;
            m = (r.id == 2'h3) ? (r.wide ? tcpf_pkg::TCPF_GIMBAL : tcpf_pkg::TCPF_DUAL)
                               : (r.wide ? tcpf_pkg::TCPF_TILT : tcpf_pkg::TCPF_SINGLE);
            {pitch, roll} = (m == tcpf_pkg::TCPF_SINGLE) ? {~r.a1, ~r.a2} : {r.a1, r.a2};
            {spin, incline} = (m == tcpf_pkg::TCPF_SINGLE) ? {r.a1, r.a2} : {~r.a1, ~r.a2};
            e1 = clamp(r.a1, r.fine ? 16'h8c9f : 16'h0e0f);
            e2 = clamp(r.a2, r.fine ? 16'h4650 : 16'h0708);
            boot(r.id, r.wide, 1'b0, r.wdog);
            check("node_addr", node_addr, 8'ha2 + r.id);
            check("node_priority", node_priority, r.id);
            check("node_id", node_id, r.id);
            check("meas_mode", meas_mode, m);
            warm_end();
            next_frame();
            next_frame();
            check("frame", frame, {r.wdog, 2'h0, r.sync, 4'h0, e2, e1});
        end
        for (int s = 0; s < 2; s++) begin
            boot(2'h3, 1'b0, s[0], 1'b0);
            next_frame();
            check("warm status bit", frame[32], 1'b1);
            warm_end();
            n = cycles - t0;
            check("warm length", (n >= (s ? WS : WF)) && (n <= (s ? WS : WF) + 3), 1);
            next_frame();
            t0 = cycles;
            next_frame();
            check("frame period", cycles - t0, FC);
            step = 1;
            @(negedge clk);
            step = 0;
            check("settle start", settling, 1'b1);
            n = 0;
            while (settling === 1'b1 && n < 200) begin
                n++;
                @(negedge clk);
            end
            check("settle length", (n >= (s ? SS : SF) - 1) && (n <= (s ? SS : SF) + 1), 1);
        end
        strap_lo = 0;
        pitch = 16'h0123;
        next_frame();
        next_frame();
        check("id fault bit", frame[38], 1'b1);
        check("addr kept", node_addr, 8'ha5);
        stall = 1;
        seen = 0;
        repeat (4 * FC) begin
            @(negedge clk);
            seen = seen | (frame_skipped === 1'b1);
        end
        check("frame skipped", seen, 1'b1);
        stall = 0;
        next_frame();
        next_frame();
        check("frame bytes after stall", frame[15:0], 16'h0123);
        check("frame length", len_err, 0);
        factory_id_en = 1;
        factory_id = 2'h2;
        boot(2'h3, 1'b0, 1'b0, 1'b0);
        check("factory addr", node_addr, 8'ha4);
        check("factory mode", meas_mode, tcpf_pkg::TCPF_SINGLE);
        summarize();
    end
endmodule
